// ---- rtl/mii_carrier_defs.svh ----
`ifndef MII_CARRIER_DEFS_SVH
`define MII_CARRIER_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and bit time
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS         4
`define BIT_TIME_NS           10

// ----------------------------------------------------------------------
// Carrier and collision limits, in bit times
// ----------------------------------------------------------------------
`define TX_CRS_ON_MIN_BT      2
`define TX_CRS_OFF_MIN_BT_TP  2
`define TX_CRS_OFF_MIN_BT_FX  1
`define TX_LAT_BT_TP          5
`define TX_LAT_BT_FX          4
`define RX_CRS_ON_MIN_BT_TP   11
`define RX_CRS_ON_MIN_BT_FX   9
`define RX_CRS_OFF_MIN_BT_TP  10
`define RX_CRS_OFF_MIN_BT_FX  13
`define RX_COL_ON_MIN_BT      10
`define RX_COL_OFF_MIN_BT_TP  14
`define RX_COL_OFF_MIN_BT_FX  13

// ----------------------------------------------------------------------
// Bit times to clock cycles, least rounds up, typical rounds down
// ----------------------------------------------------------------------
`define BT_CYC_UP(bt) ((((bt) * `BIT_TIME_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BT_CYC_DN(bt) (((bt) * `BIT_TIME_NS) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Fixed path latencies in clock cycles, delay line depth
// ----------------------------------------------------------------------
`define TX_PATH_CYC           5
`define RX_CRS_PATH_CYC       2
`define RX_COL_PATH_CYC       1
`define TX_DLY_DEPTH          16

`endif

// ---- rtl/mii_carrier_pkg.sv ----
package mii_carrier_pkg;

    // ------------------------------------------------------------------
    // Nibble word carried between MII and line
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       stb;
        logic       en;
        logic       er;
        logic [3:0] nib;
    } nib_word_t;

    typedef enum logic [1:0] {TXC_OFF, TXC_RISE, TXC_ON, TXC_FALL} tx_crs_state_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_CARRIER, RX_END} rx_state_t;

endpackage

// ---- rtl/stage_delay.sv ----
`timescale 1ns/1ps

module stage_delay
    import mii_carrier_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic      clk,
    input  wire logic      arst_n,
    input  wire nib_word_t din,
    input  wire logic [3:0] tap,
    output nib_word_t      dout
);

    // ------------------------------------------------------------------
    // Shift stages
    // ------------------------------------------------------------------
    nib_word_t stage_q [DEPTH];
    nib_word_t dout_d;
    nib_word_t dout_q;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage_q[i] <= '0;
                end else if (i == 0) begin
                    stage_q[i] <= din;
                end else begin
                    stage_q[i] <= stage_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Registered tap
    // ------------------------------------------------------------------
    always_comb begin
        dout_d = stage_q[tap];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_q <= '0;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign dout = dout_q;

endmodule

// ---- rtl/phy_mii_fast_carrier.sv ----
// Operation
// - CRS rises 2 to 5 bit times after TXEN sampled high.
// - CRS falls after TXEN low: 2-5 bit times twisted pair, 1-5 fiber.
// - First transmit symbol reaches twisted-pair line about 5 bit times after TXEN.
// - First transmit symbol reaches fiber output about 4 bit times after TXEN.
// - RXDV with valid nibbles follows CRS rise by 3 to 5 bit times.
// - CRS rises after J start: 11-16 bit times pair, 9-14 fiber.
// - CRS falls after T start: 10-17 bit times pair, 13-17 fiber.
// - COL rises after J during transmit: 10-15 pair, 10-14 fiber.
// - COL falls after T start: 14-20 bit times pair, 13-18 fiber.
// - RXD, RXDV, RXER stay stable around each rising MII clock.
`timescale 1ns/1ps
`include "mii_carrier_defs.svh"

module phy_mii_fast_carrier
    import mii_carrier_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       MII_CLK,
    input  wire logic [3:0] TXD,
    input  wire logic       TX_EN,
    input  wire logic       TX_ER,
    output logic      [3:0] RXD,
    output logic            RX_DV,
    output logic            RX_ER,
    output logic            CRS,
    output logic            COL,
    input  wire logic       MEDIA_FIBER,
    output nib_word_t       LINE_TX_WORD,
    output logic            LINE_TX_START,
    input  wire nib_word_t  LINE_RX_WORD,
    input  wire logic       LINE_RX_J,
    input  wire logic       LINE_RX_T
);

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam int TXON_I  = `BT_CYC_UP(`TX_CRS_ON_MIN_BT) - `TX_PATH_CYC;
    localparam int TXOFT_I = `BT_CYC_UP(`TX_CRS_OFF_MIN_BT_TP) - `TX_PATH_CYC;
    localparam int TXOFF_I = `BT_CYC_UP(`TX_CRS_OFF_MIN_BT_FX) - `TX_PATH_CYC;
    localparam logic [5:0] TX_ON_WAIT  = 6'((TXON_I > 0) ? TXON_I : 0);
    localparam logic [5:0] TX_OFF_TP   = 6'((TXOFT_I > 0) ? TXOFT_I : 0);
    localparam logic [5:0] TX_OFF_FX   = 6'((TXOFF_I > 0) ? TXOFF_I : 0);
    localparam logic [3:0] TX_TAP_TP   = 4'(`BT_CYC_DN(`TX_LAT_BT_TP) - `TX_PATH_CYC);
    localparam logic [3:0] TX_TAP_FX   = 4'(`BT_CYC_DN(`TX_LAT_BT_FX) - `TX_PATH_CYC);
    localparam logic [5:0] CRS_ON_TP   = 6'(`BT_CYC_UP(`RX_CRS_ON_MIN_BT_TP) - `RX_CRS_PATH_CYC);
    localparam logic [5:0] CRS_ON_FX   = 6'(`BT_CYC_UP(`RX_CRS_ON_MIN_BT_FX) - `RX_CRS_PATH_CYC);
    localparam logic [5:0] CRS_OFF_TP  = 6'(`BT_CYC_UP(`RX_CRS_OFF_MIN_BT_TP) - `RX_CRS_PATH_CYC);
    localparam logic [5:0] CRS_OFF_FX  = 6'(`BT_CYC_UP(`RX_CRS_OFF_MIN_BT_FX) - `RX_CRS_PATH_CYC);
    localparam logic [5:0] COL_ON      = 6'(`BT_CYC_UP(`RX_COL_ON_MIN_BT) - `RX_COL_PATH_CYC);
    localparam logic [5:0] COL_OFF_TP  = 6'(`BT_CYC_UP(`RX_COL_OFF_MIN_BT_TP) - `RX_COL_PATH_CYC);
    localparam logic [5:0] COL_OFF_FX  = 6'(`BT_CYC_UP(`RX_COL_OFF_MIN_BT_FX) - `RX_COL_PATH_CYC);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    nib_word_t [1:0] tx_slot_q, tx_slot_d;
    logic            mtog_q, mtog_d;
    logic            ttog_s1_q, ttog_s2_q, ttog_s3_q;
    logic            fib_s1_q, fib_s2_q;
    nib_word_t       tx_word_q, tx_word_d;
    logic            tx_new;
    logic            fiber;
    nib_word_t       dly_out;
    logic            line_en_q, line_en_d;
    logic            start_q, start_d;
    tx_crs_state_t   txc_q, txc_d;
    logic [5:0]      txc_cnt_q, txc_cnt_d;
    rx_state_t       rx_q, rx_d;
    logic [5:0]      rx_cnt_q, rx_cnt_d;
    logic            crs_rx_q, crs_rx_d;
    logic            col_q, col_d;
    logic            crs_q, crs_d;
    nib_word_t [1:0] rx_slot_q, rx_slot_d;
    logic            rtog_q, rtog_d;
    logic            rtog_s1_q, rtog_s2_q, rtog_s3_q;
    nib_word_t       rx_out_q, rx_out_d;

    // ------------------------------------------------------------------
    // MII transmit capture, ping-pong slots on the MII clock
    // ------------------------------------------------------------------
    always_comb begin
        tx_slot_d          = tx_slot_q;
        mtog_d             = ~mtog_q;
        tx_slot_d[~mtog_q] = '{stb: 1'b1, en: TX_EN, er: TX_ER, nib: TXD};
    end

    always_ff @(posedge MII_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_slot_q <= '0;
            mtog_q    <= 1'b0;
            rtog_s1_q <= 1'b0;
            rtog_s2_q <= 1'b0;
            rtog_s3_q <= 1'b0;
        end else begin
            tx_slot_q <= tx_slot_d;
            mtog_q    <= mtog_d;
            rtog_s1_q <= rtog_q;
            rtog_s2_q <= rtog_s1_q;
            rtog_s3_q <= rtog_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Core side synchronisers and transmit word pickup
    // ------------------------------------------------------------------
    always_comb begin
        tx_new        = ttog_s2_q ^ ttog_s3_q;
        fiber         = fib_s2_q;
        tx_word_d     = tx_word_q;
        tx_word_d.stb = 1'b0;
        if (tx_new) begin
            tx_word_d = tx_slot_q[ttog_s2_q];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ttog_s1_q <= 1'b0;
            ttog_s2_q <= 1'b0;
            ttog_s3_q <= 1'b0;
            fib_s1_q  <= 1'b0;
            fib_s2_q  <= 1'b0;
            tx_word_q <= '0;
        end else begin
            ttog_s1_q <= mtog_q;
            ttog_s2_q <= ttog_s1_q;
            ttog_s3_q <= ttog_s2_q;
            fib_s1_q  <= MEDIA_FIBER;
            fib_s2_q  <= fib_s1_q;
            tx_word_q <= tx_word_d;
        end
    end

    // ------------------------------------------------------------------
    // Transmit latency to the line
    // ------------------------------------------------------------------
    stage_delay #(
        .DEPTH (`TX_DLY_DEPTH)
    ) u_tx_delay (
        .clk    (CLK),
        .arst_n (ARST_N),
        .din    (tx_word_q),
        .tap    (fiber ? TX_TAP_FX : TX_TAP_TP),
        .dout   (dly_out)
    );

    always_comb begin
        line_en_d = dly_out.en;
        start_d   = dly_out.en & ~line_en_q;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            line_en_q <= 1'b0;
            start_q   <= 1'b0;
        end else begin
            line_en_q <= line_en_d;
            start_q   <= start_d;
        end
    end

    // ------------------------------------------------------------------
    // Transmit carrier sense
    // ------------------------------------------------------------------
    always_comb begin
        txc_d     = txc_q;
        txc_cnt_d = txc_cnt_q + 6'h01;
        case (txc_q)
            TXC_OFF: begin
                txc_cnt_d = '0;
                if (tx_word_q.en) begin
                    txc_d = TXC_RISE;
                end
            end
            TXC_RISE: begin
                if (!tx_word_q.en) begin
                    txc_d = TXC_OFF;
                end else if (txc_cnt_q >= TX_ON_WAIT) begin
                    txc_d = TXC_ON;
                end
            end
            TXC_ON: begin
                txc_cnt_d = '0;
                if (!tx_word_q.en) begin
                    txc_d = TXC_FALL;
                end
            end
            TXC_FALL: begin
                if (tx_word_q.en) begin
                    txc_d = TXC_ON;
                end else if (txc_cnt_q >= (fiber ? TX_OFF_FX : TX_OFF_TP)) begin
                    txc_d = TXC_OFF;
                end
            end
            default: begin
                txc_d = TXC_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            txc_q     <= TXC_OFF;
            txc_cnt_q <= '0;
        end else begin
            txc_q     <= txc_d;
            txc_cnt_q <= txc_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Receive carrier and collision from line delimiters
    // ------------------------------------------------------------------
    always_comb begin
        rx_d     = rx_q;
        rx_cnt_d = rx_cnt_q + 6'h01;
        crs_rx_d = crs_rx_q;
        col_d    = col_q;
        case (rx_q)
            RX_IDLE: begin
                rx_cnt_d = '0;
                crs_rx_d = 1'b0;
                col_d    = 1'b0;
                if (LINE_RX_J) begin
                    rx_d = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt_q == (fiber ? CRS_ON_FX : CRS_ON_TP)) begin
                    crs_rx_d = 1'b1;
                end
                if (rx_cnt_q == COL_ON && tx_word_q.en) begin
                    col_d = 1'b1;
                end
                if (LINE_RX_T) begin
                    rx_cnt_d = '0;
                    rx_d     = RX_END;
                end else if (rx_cnt_q >= CRS_ON_TP) begin
                    rx_d = RX_CARRIER;
                end
            end
            RX_CARRIER: begin
                rx_cnt_d = '0;
                if (LINE_RX_T) begin
                    rx_d = RX_END;
                end
            end
            RX_END: begin
                if (rx_cnt_q == (fiber ? CRS_OFF_FX : CRS_OFF_TP)) begin
                    crs_rx_d = 1'b0;
                end
                if (rx_cnt_q == (fiber ? COL_OFF_FX : COL_OFF_TP)) begin
                    col_d = 1'b0;
                end
                if (rx_cnt_q >= COL_OFF_TP) begin
                    rx_d = RX_IDLE;
                end
            end
            default: begin
                rx_d = RX_IDLE;
            end
        endcase
        crs_d = crs_rx_q | (txc_q == TXC_ON) | (txc_q == TXC_FALL);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_q     <= RX_IDLE;
            rx_cnt_q <= '0;
            crs_rx_q <= 1'b0;
            col_q    <= 1'b0;
            crs_q    <= 1'b0;
        end else begin
            rx_q     <= rx_d;
            rx_cnt_q <= rx_cnt_d;
            crs_rx_q <= crs_rx_d;
            col_q    <= col_d;
            crs_q    <= crs_d;
        end
    end

    // ------------------------------------------------------------------
    // Receive nibbles into ping-pong slots on the core clock
    // ------------------------------------------------------------------
    always_comb begin
        rx_slot_d = rx_slot_q;
        rtog_d    = rtog_q;
        if (LINE_RX_WORD.stb) begin
            rx_slot_d[~rtog_q]    = LINE_RX_WORD;
            rx_slot_d[~rtog_q].en = LINE_RX_WORD.en & crs_rx_q;
            rtog_d                = ~rtog_q;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_slot_q <= '0;
            rtog_q    <= 1'b0;
        end else begin
            rx_slot_q <= rx_slot_d;
            rtog_q    <= rtog_d;
        end
    end

    // ------------------------------------------------------------------
    // Receive outputs launched on the falling MII edge
    // ------------------------------------------------------------------
    always_comb begin
        rx_out_d = '0;
        if (rtog_s2_q ^ rtog_s3_q) begin
            rx_out_d = rx_slot_q[rtog_s2_q];
        end
    end

    always_ff @(negedge MII_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_out_q <= '0;
        end else begin
            rx_out_q <= rx_out_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign RXD           = rx_out_q.nib;
    assign RX_DV         = rx_out_q.en;
    assign RX_ER         = rx_out_q.er & rx_out_q.en;
    assign CRS           = crs_q;
    assign COL           = col_q;
    assign LINE_TX_WORD  = dly_out;
    assign LINE_TX_START = start_q;

endmodule

// ---- test/phy_mii_fast_carrier_properties.sv ----
`timescale 1ns/1ps
module phy_mii_carrier_checker
    import mii_carrier_pkg::*;
(
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       MII_CLK,
    input wire logic       TX_EN,
    input wire logic [3:0] RXD,
    input wire logic       RX_DV,
    input wire logic       RX_ER,
    input wire logic       CRS,
    input wire logic       COL,
    input wire logic       MEDIA_FIBER,
    input wire logic       LINE_TX_START,
    input wire logic       LINE_RX_J,
    input wire logic       LINE_RX_T
);
    // ------
    // Carrier and collision timing
    // ------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_tx_crs_on: assert property ($rose(TX_EN) && !CRS |-> !CRS[*4] ##[1:11] CRS)
        else $error("carrier rise off window after transmit start");
    a_tx_crs_off: assert property ($fell(TX_EN) && CRS |-> CRS[*3] ##[1:11] !CRS)
        else $error("carrier fall off window after transmit end");
    a_tx_lat_pair: assert property ($rose(TX_EN) && !MEDIA_FIBER |-> ##[10:16] LINE_TX_START)
        else $error("pair transmit latency off");
    a_tx_lat_fiber: assert property ($rose(TX_EN) && MEDIA_FIBER |-> ##[8:14] LINE_TX_START)
        else $error("fiber transmit latency off");
    a_rx_dv_lag: assert property ($rose(CRS) && !TX_EN |-> !RX_DV[*6] ##[1:7] RX_DV)
        else $error("receive valid off window after carrier");
    a_rx_on_pair: assert property (LINE_RX_J && !TX_EN && !MEDIA_FIBER |->
        ##28 !CRS ##[1:13] CRS)
        else $error("pair carrier rise after start delimiter off");
    a_rx_on_fiber: assert property (LINE_RX_J && !TX_EN && MEDIA_FIBER |->
        ##23 !CRS ##[1:13] CRS)
        else $error("fiber carrier rise after start delimiter off");
    a_rx_off_pair: assert property (LINE_RX_T && !TX_EN && !MEDIA_FIBER |->
        ##25 CRS ##[1:18] !CRS)
        else $error("pair carrier fall after end delimiter off");
    a_rx_off_fiber: assert property (LINE_RX_T && !TX_EN && MEDIA_FIBER |->
        ##33 CRS ##[1:10] !CRS)
        else $error("fiber carrier fall after end delimiter off");
    a_col_on: assert property (LINE_RX_J && TX_EN |-> ##25 !COL ##[1:11] COL)
        else $error("collision rise off window");
    a_col_off_pair: assert property (LINE_RX_T && COL && !MEDIA_FIBER |->
        ##35 COL ##[1:16] !COL)
        else $error("pair collision fall off window");
    a_col_off_fiber: assert property (LINE_RX_T && COL && MEDIA_FIBER |->
        ##33 COL ##[1:13] !COL)
        else $error("fiber collision fall off window");
    a_rx_launch: assert property ($changed({RX_DV, RX_ER, RXD}) |-> !MII_CLK)
        else $error("receive outputs moved near rising mii clock");

    cover property ($rose(COL));
    cover property (LINE_TX_START && MEDIA_FIBER);
    cover property ($rose(RX_DV));
endmodule

bind phy_mii_fast_carrier phy_mii_carrier_checker u_chk (.CLK(CLK), .ARST_N(ARST_N),
    .MII_CLK(MII_CLK), .TX_EN(TX_EN), .RXD(RXD), .RX_DV(RX_DV), .RX_ER(RX_ER), .CRS(CRS),
    .COL(COL), .MEDIA_FIBER(MEDIA_FIBER), .LINE_TX_START(LINE_TX_START),
    .LINE_RX_J(LINE_RX_J), .LINE_RX_T(LINE_RX_T));

// ---- test/mac_model.sv ----
`timescale 1ns/1ps
module mac_model (
    input  wire logic       mii_clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    input  wire logic [3:0] base,
    output logic      [3:0] txd,
    output logic            tx_en,
    output logic            tx_er,
    input  wire logic [3:0] rxd,
    input  wire logic       rx_dv,
    input  wire logic       rx_er,
    output logic      [3:0] rx_first,
    output logic      [3:0] rx_last,
    output logic      [7:0] rx_cnt
);
    logic [7:0] left = 8'h00;
    logic [3:0] cur  = 4'h0;
    logic [3:0] quiet = 4'hf;
    initial begin
        txd = 4'h0;
        tx_en = 1'b0;
        tx_er = 1'b0;
        rx_cnt = 8'h00;
        rx_first = 4'h0;
        rx_last = 4'h0;
    end
    // Launch off falling edge, idle data inverts each cycle
    always @(negedge mii_clk) begin
        if (left != 8'h00) begin
            tx_en <= 1'b1;
            txd <= cur;
            cur <= cur + 4'h1;
            left <= left - 8'h01;
        end else begin
            tx_en <= 1'b0;
            txd <= ~txd;
            if (go) begin
                left <= len;
                cur <= base;
            end
        end
    end
    // Capture receive nibbles on rising edge, first one after a long quiet
    always @(posedge mii_clk) begin
        if (rx_dv) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
        if (rx_dv && !rx_er) begin
            rx_cnt <= rx_cnt + 8'h01;
            rx_last <= rxd;
            if (quiet == 4'hf) begin
                rx_first <= rxd;
            end
        end
    end
endmodule

// ---- test/tb_phy_mii_fast_carrier.sv ----
`timescale 1ns/1ps
module tb_phy_mii_fast_carrier
    import mii_carrier_pkg::*;
;
    logic       clk = 1'b0;
    logic       mii_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       fiber = 1'b0;
    logic       go = 1'b0;
    logic       rx_j = 1'b0;
    logic       rx_t = 1'b0;
    logic [7:0] len = 8'h06;
    logic [3:0] base = 4'h0;
    nib_word_t  rx_word = '0;
    nib_word_t  tx_word;
    logic [3:0] txd, rxd, rx_first, rx_last;
    logic       tx_en, tx_er, rx_dv, rx_er, crs, col, tx_start;
    logic [7:0] rx_cnt;
    logic [3:0] txq[$];
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         starts = 0;

    always #2 clk = ~clk;
    initial begin
        #1.3;
        forever #7.5 mii_clk = ~mii_clk;
    end

    phy_mii_fast_carrier uut (.CLK(clk), .ARST_N(arst_n), .MII_CLK(mii_clk), .TXD(txd),
        .TX_EN(tx_en), .TX_ER(tx_er), .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er), .CRS(crs),
        .COL(col), .MEDIA_FIBER(fiber), .LINE_TX_WORD(tx_word), .LINE_TX_START(tx_start),
        .LINE_RX_WORD(rx_word), .LINE_RX_J(rx_j), .LINE_RX_T(rx_t));
    mac_model mac (.mii_clk(mii_clk), .go(go), .len(len), .base(base), .txd(txd),
        .tx_en(tx_en), .tx_er(tx_er), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .rx_first(rx_first), .rx_last(rx_last), .rx_cnt(rx_cnt));

    // ------
    // Line monitor and timeout
    // ------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_word.stb && tx_word.en) begin
            txq.push_back(tx_word.nib);
        end
        if (tx_start) begin
            starts <= starts + 1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wait_lvl(input int sel, input logic v, output int n);
        n = 0;
        while ((sel == 0 ? crs : sel == 1 ? col : tx_en) !== v && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic pulse(input bit is_t);
        rx_t = is_t;
        rx_j = !is_t;
        @(negedge clk);
        rx_t = 1'b0;
        rx_j = 1'b0;
    endtask

    // ------
    // Scenarios
    // ------
    task automatic tx_frame(input bit f);
        int n;
        int s0;
        fiber = f;
        base = {3'h2, f};
        len = 8'h06;
        repeat (4) @(negedge clk);
        txq.delete();
        s0 = starts;
        go = 1'b1;
        wait_lvl(2, 1'b1, n);
        go = 1'b0;
        wait_lvl(0, 1'b1, n);
        check_rng("tx carrier on", 6, 14, n);
        wait_lvl(0, 1'b0, n);
        repeat (20) @(negedge clk);
        check("line start pulses", 8'h01, 8'(starts - s0));
        check("line nibble count", 8'h06, 8'(txq.size()));
        for (int i = 0; i < 6; i++) begin
            check("line nibble", {4'h0, 4'(base + i)}, {4'h0, txq[i]});
        end
    endtask

    task automatic rx_frame(input bit f);
        int n;
        logic [7:0] c0;
        fiber = f;
        repeat (4) @(negedge clk);
        c0 = rx_cnt;
        pulse(1'b1 == 1'b0);
        for (int i = 0; i < 14; i++) begin
            rx_word = '{1'b1, 1'b1, (i == 10), 4'(i)};
            @(negedge clk);
            rx_word.stb = 1'b0;
            repeat (4) @(negedge clk);
        end
        check("rx carrier up", 8'h01, {7'h0, crs});
        pulse(1'b1);
        wait_lvl(0, 1'b0, n);
        check_rng("rx carrier off", f ? 33 : 25, 42, n);
        repeat (20) @(negedge clk);
        rx_word = '0;
        check_rng("first nibble", 5, 9, int'(rx_first));
        check("last nibble", 8'h0d, {4'h0, rx_last});
        check("nibble count", {4'h0, 4'(rx_last - rx_first)}, 8'(rx_cnt - c0));
    endtask

    task automatic collision(input bit f);
        int n;
        fiber = f;
        len = 8'h3c;
        repeat (4) @(negedge clk);
        go = 1'b1;
        wait_lvl(2, 1'b1, n);
        go = 1'b0;
        repeat (8) @(negedge clk);
        pulse(1'b0);
        wait_lvl(1, 1'b1, n);
        check_rng("col on", 25, f ? 35 : 37, n);
        pulse(1'b1);
        wait_lvl(1, 1'b0, n);
        check_rng("col off", f ? 33 : 35, f ? 45 : 50, n);
        check("carrier held by transmit", 8'h01, {7'h0, crs});
        wait_lvl(2, 1'b0, n);
        wait_lvl(0, 1'b0, n);
        check_rng("carrier off after transmit", f ? 4 : 6, 15, n);
        repeat (20) @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int f = 0; f < 2; f++) begin
            tx_frame(f[0]);
            rx_frame(f[0]);
            collision(f[0]);
        end
        end_of_test();
    end
endmodule
